// ==== scd_map.svh ====
// Register indices, field layouts, reset values and command codes of the scroll/cursor/depth bank
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define SCD_IDX_PIXEL_SCROLL      8'h1b
`define SCD_IDX_CURSOR_WRITE_LOW  8'h1c
`define SCD_IDX_CURSOR_WRITE_HIGH 8'h1d
`define SCD_IDX_CURSOR_READ_LOW   8'h1e
`define SCD_IDX_CURSOR_READ_HIGH  8'h1f
`define SCD_IDX_PIXEL_DEPTH       8'h20
`define SCD_IDX_COMMAND           8'h30
`define SCD_IDX_PARAM_DATA        8'h31

// Field layouts
`define SCD_SCROLL_MSB            2
`define SCD_DEPTH_MSB             1

// Reset values
`define SCD_RST_PIXEL_SCROLL      3'h0
`define SCD_RST_CURSOR            16'h0000
`define SCD_RST_PIXEL_DEPTH       2'h0

// Depth encodings
`define SCD_DEPTH_1BPP            2'h0
`define SCD_DEPTH_2BPP            2'h1
`define SCD_DEPTH_4BPP            2'h2

// Indirect command control bytes
`define SCD_CODE_DOT_SCROLL       8'h5a
`define SCD_CODE_CURSOR_LOAD      8'h46
`define SCD_CODE_CURSOR_FETCH     8'h47
`define SCD_CODE_PIXEL_DEPTH      8'h60
`define SCD_CODE_MEMORY_STORE     8'h42
`define SCD_CODE_MEMORY_FETCH     8'h43

`endif

// ==== scd_pkg.sv ====
// Types shared by the scroll/cursor/depth register bank
package scd_pkg;

  // Indirect command in progress, Gray coded along the usual order of use
  typedef enum logic [2:0] {
    CMD_NONE         = 3'b000,
    CMD_CURSOR_LOAD  = 3'b001,
    CMD_MEM_STORE    = 3'b011,
    CMD_MEM_FETCH    = 3'b010,
    CMD_CURSOR_FETCH = 3'b110,
    CMD_SCROLL       = 3'b111,
    CMD_DEPTH        = 3'b101
  } cmd_state_type;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

endpackage

// ==== display_ram.sv ====
// Display memory with a host port at the cursor and a registered fetch port
`timescale 1ns/1ps
module display_ram #(
  parameter int ADDR_W = 16
) (
  // Clock
  input  wire logic              clk_sys_in,
  // Host port, read is combinational
  input  wire logic              host_we_in,
  input  wire logic [ADDR_W-1:0] host_addr_in,
  input  wire logic [7:0]        host_wdata_in,
  output logic      [7:0]        host_rdata_out,
  // Display fetch port, data one cycle after the request
  input  wire logic              disp_rd_in,
  input  wire logic [ADDR_W-1:0] disp_addr_in,
  output logic      [7:0]        disp_rdata_out
);

  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] disp_rdata_q;

  // Host write; no reset, memory content is undefined after power up
  always_ff @(posedge clk_sys_in)
  begin
    if (host_we_in)
      mem[host_addr_in] <= host_wdata_in;
  end

  // Display read is registered so the refresh path stays short
  always_ff @(posedge clk_sys_in)
  begin
    if (disp_rd_in)
      disp_rdata_q <= mem[disp_addr_in];
  end

  assign host_rdata_out = mem[host_addr_in];
  assign disp_rdata_out = disp_rdata_q;

endmodule // display_ram

// ==== pixel_shifter.sv ====
// Horizontal pixel shifter applied to the whole fetched byte stream
`timescale 1ns/1ps
module pixel_shifter (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Incoming display bytes
  input  wire logic       byte_valid_in,
  input  wire logic [7:0] byte_in,
  input  wire logic [2:0] shift_in,
  // Shifted display bytes
  output logic            pixels_valid_out,
  output logic      [7:0] pixels_out
);

  logic [7:0]  prev_q;
  logic [7:0]  pixels_q;
  logic        valid_q;
  logic [15:0] pair;
  logic [15:0] shifted;

  // Left pixel is the MSB; output lags one byte, hence the extra byte per row
  assign pair    = {prev_q, byte_in};
  assign shifted = pair << shift_in;

  // Stream registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_q   <= 8'h00;
      pixels_q <= 8'h00;
      valid_q  <= 1'b0;
    end
    else
    begin
      valid_q <= byte_valid_in;
      if (byte_valid_in)
      begin
        prev_q   <= byte_in;
        pixels_q <= shifted[15:8];
      end
    end
  end

  assign pixels_valid_out = valid_q;
  assign pixels_out       = pixels_q;

endmodule // pixel_shifter

// ==== scroll_cursor_depth_regs.sv ====
// Scroll, cursor and pixel depth register bank with indirect command path over APB
// Operation
// - Pixel scroll shifts the whole display, never a single layer.
// - Text display shifts by the pixel count in the 3-bit scroll field.
// - A 16-bit write-only cursor address, low byte first register, high second.
// - Indirect mode gives no direct display memory access; commands only.
// - Memory fetch and store commands use the current cursor address.
// - Cursor changes only by cursor load or increment after memory access.
// - Scroll operations never change the cursor address.
// - Without a new load, access uses last address plus increments.
// - Current cursor is shown in two read-only cursor read registers.
// - After cursor fetch, first read gives low byte, second high byte.
// - Depth field: 00 one bit, 01 two, 10 four, 11 reserved.
// - Dot scroll command takes the pixel scroll register as its parameter.
// - Cursor load command takes the two cursor write registers as parameters.
// - Pixel depth command takes the depth register as its parameter.
// - Dot scroll command is control byte 5A with one parameter.
// - Pixel depth command is control byte 60h with one parameter.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "scd_map.svh"
module scroll_cursor_depth_regs #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  // APB slave
  input  wire scd_pkg::apb_req_type apb_req_in,
  output logic                      pready_out,
  output logic               [31:0] prdata_out,
  output logic                      pslverr_out,
  // Display fetch stream
  input  wire logic                 disp_rd_in,
  input  wire logic    [ADDR_W-1:0] disp_addr_in,
  output logic                      disp_valid_out,
  output logic                [7:0] disp_pixels_out,
  // Settings seen by the display engine
  output logic                [2:0] pixel_scroll_out,
  output logic                [2:0] depth_bpp_out,
  output logic                      depth_reserved_out,
  output logic               [15:0] cursor_out
);

  // Bus decode
  logic [7:0] word_idx;
  logic       addr_ok;
  logic       setup_ph;
  logic       acc_ph;
  logic       acc_wr;
  logic       acc_rd;
  logic       sel_scroll;
  logic       sel_cw_low;
  logic       sel_cw_high;
  logic       sel_cr_low;
  logic       sel_cr_high;
  logic       sel_depth;
  logic       sel_cmd;
  logic       sel_data;
  logic       mapped;

  // Register state
  logic [2:0]  scroll_q;
  logic [2:0]  scroll_d;
  logic [7:0]  cw_low_q;
  logic [7:0]  cw_low_d;
  logic [7:0]  cw_high_q;
  logic [7:0]  cw_high_d;
  logic [1:0]  depth_q;
  logic [1:0]  depth_d;
  logic [15:0] cursor_q;
  logic [15:0] cursor_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        slverr_q;

  // Command engine
  scd_pkg::cmd_state_type cmd_q;
  scd_pkg::cmd_state_type cmd_d;
  logic [1:0]  param_q;
  logic [1:0]  param_d;
  logic        data_wr;
  logic        data_rd;
  logic        p_first;
  logic        p_second;
  logic        scroll_par_wr;
  logic        depth_par_wr;
  logic        cload_low_wr;
  logic        cload_high_wr;
  logic        mem_store;
  logic        mem_fetch;
  logic        cursor_load;
  logic        cursor_step;
  logic [7:0]  cmd_code;
  logic [7:0]  mem_rdata;
  logic [7:0]  data_rdata;
  logic [7:0]  disp_byte;
  logic        disp_byte_valid_q;

  // Word index from the byte address; unaligned or out-of-range addresses are unmapped
  assign word_idx    = apb_req_in.paddr[9:2];
  assign addr_ok     = (apb_req_in.paddr[1:0] == 2'h0) && (apb_req_in.paddr[11:10] == 2'h0);
  assign setup_ph    = apb_req_in.psel && !apb_req_in.penable;
  assign acc_ph      = apb_req_in.psel && apb_req_in.penable;
  assign acc_wr      = acc_ph && apb_req_in.pwrite;
  assign acc_rd      = acc_ph && !apb_req_in.pwrite;
  assign sel_scroll  = addr_ok && (word_idx == `SCD_IDX_PIXEL_SCROLL);
  assign sel_cw_low  = addr_ok && (word_idx == `SCD_IDX_CURSOR_WRITE_LOW);
  assign sel_cw_high = addr_ok && (word_idx == `SCD_IDX_CURSOR_WRITE_HIGH);
  assign sel_cr_low  = addr_ok && (word_idx == `SCD_IDX_CURSOR_READ_LOW);
  assign sel_cr_high = addr_ok && (word_idx == `SCD_IDX_CURSOR_READ_HIGH);
  assign sel_depth   = addr_ok && (word_idx == `SCD_IDX_PIXEL_DEPTH);
  assign sel_cmd     = addr_ok && (word_idx == `SCD_IDX_COMMAND);
  assign sel_data    = addr_ok && (word_idx == `SCD_IDX_PARAM_DATA);
  assign mapped      = sel_scroll | sel_cw_low | sel_cw_high | sel_cr_low
                     | sel_cr_high | sel_depth | sel_cmd | sel_data;

  // Parameter and data port strobes, qualified by the command in progress
  assign data_wr       = acc_wr && sel_data;
  assign data_rd       = acc_rd && sel_data;
  assign p_first       = (param_q == 2'd0);
  assign p_second      = (param_q == 2'd1);
  assign scroll_par_wr = data_wr && (cmd_q == scd_pkg::CMD_SCROLL) && p_first;
  assign depth_par_wr  = data_wr && (cmd_q == scd_pkg::CMD_DEPTH) && p_first;
  assign cload_low_wr  = data_wr && (cmd_q == scd_pkg::CMD_CURSOR_LOAD) && p_first;
  assign cload_high_wr = data_wr && (cmd_q == scd_pkg::CMD_CURSOR_LOAD) && p_second;
  assign mem_store     = data_wr && (cmd_q == scd_pkg::CMD_MEM_STORE);
  assign mem_fetch     = data_rd && (cmd_q == scd_pkg::CMD_MEM_FETCH);

  // Command byte decode; an unknown code parks the engine so data is ignored
  assign cmd_code = apb_req_in.pwdata[7:0];
  always_comb
  begin
    cmd_d = cmd_q;
    if (acc_wr && sel_cmd)
    begin
      case (cmd_code)
        `SCD_CODE_DOT_SCROLL:   cmd_d = scd_pkg::CMD_SCROLL;
        `SCD_CODE_PIXEL_DEPTH:  cmd_d = scd_pkg::CMD_DEPTH;
        `SCD_CODE_CURSOR_LOAD:  cmd_d = scd_pkg::CMD_CURSOR_LOAD;
        `SCD_CODE_CURSOR_FETCH: cmd_d = scd_pkg::CMD_CURSOR_FETCH;
        `SCD_CODE_MEMORY_STORE: cmd_d = scd_pkg::CMD_MEM_STORE;
        `SCD_CODE_MEMORY_FETCH: cmd_d = scd_pkg::CMD_MEM_FETCH;
        default:                cmd_d = scd_pkg::CMD_NONE;
      endcase
    end
  end

  // Parameter counter restarts on a command and saturates, so surplus bytes are dropped
  assign param_d = (acc_wr && sel_cmd) ? 2'd0 :
                   ((data_wr || data_rd) && (param_q != 2'd2)) ? param_q + 2'd1 :
                   param_q;

  // Register next values, from a direct write or from a command parameter
  assign scroll_d  = (acc_wr && sel_scroll) || scroll_par_wr
                   ? apb_req_in.pwdata[`SCD_SCROLL_MSB:0] : scroll_q;
  assign depth_d   = (acc_wr && sel_depth) || depth_par_wr
                   ? apb_req_in.pwdata[`SCD_DEPTH_MSB:0] : depth_q;
  assign cw_low_d  = (acc_wr && sel_cw_low) || cload_low_wr
                   ? apb_req_in.pwdata[7:0] : cw_low_q;
  assign cw_high_d = (acc_wr && sel_cw_high) || cload_high_wr
                   ? apb_req_in.pwdata[7:0] : cw_high_q;

  // Cursor moves only by a load or a per-byte step; scroll paths never touch it
  assign cursor_load = (acc_wr && (sel_cw_low || sel_cw_high)) || cload_low_wr || cload_high_wr;
  assign cursor_step = mem_store || mem_fetch;
  assign cursor_d    = cursor_load ? {cw_high_d, cw_low_d} :
                       cursor_step ? cursor_q + 16'h0001 :
                       cursor_q;

  // Data port read: cursor bytes in order after a cursor fetch, or memory at the cursor
  always_comb
  begin
    data_rdata = 8'h00;
    case (cmd_q)
      scd_pkg::CMD_CURSOR_FETCH:
      begin
        if (p_first)
          data_rdata = cursor_q[7:0];
        else if (p_second)
          data_rdata = cursor_q[15:8];
        else
          data_rdata = 8'h00;
      end
      scd_pkg::CMD_MEM_FETCH: data_rdata = mem_rdata;
      default:                data_rdata = 8'h00;
    endcase
  end

  // Read mux; write-only cursor registers read as zero, narrow fields zero-extended
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    if (sel_scroll)
      prdata_d = {29'h0, scroll_q};
    else if (sel_cr_low)
      prdata_d = {24'h0, cursor_q[7:0]};
    else if (sel_cr_high)
      prdata_d = {24'h0, cursor_q[15:8]};
    else if (sel_depth)
      prdata_d = {30'h0, depth_q};
    else if (sel_data)
      prdata_d = {24'h0, data_rdata};
    else
      prdata_d = 32'h0000_0000;
  end

  // Control registers; all five registers of this block clear at reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scroll_q  <= `SCD_RST_PIXEL_SCROLL;
      depth_q   <= `SCD_RST_PIXEL_DEPTH;
      cw_low_q  <= 8'h00;
      cw_high_q <= 8'h00;
      cursor_q  <= `SCD_RST_CURSOR;
    end
    else
    begin
      scroll_q  <= scroll_d;
      depth_q   <= depth_d;
      cw_low_q  <= cw_low_d;
      cw_high_q <= cw_high_d;
      cursor_q  <= cursor_d;
    end
  end

  // Command engine state
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_q   <= scd_pkg::CMD_NONE;
      param_q <= 2'd0;
    end
    else
    begin
      cmd_q   <= cmd_d;
      param_q <= param_d;
    end
  end

  // Read data captured in the setup cycle; nothing it depends on moves before the access edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_q <= apb_req_in.pwrite ? 32'h0000_0000 : prdata_d;
      slverr_q <= !mapped;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready_out  = 1'b1;
  assign prdata_out  = prdata_q;
  assign pslverr_out = slverr_q && acc_ph;

  // Display memory, reached by the host only through the cursor
  display_ram #(
    .ADDR_W (ADDR_W)
  ) u_display_ram (
    .clk_sys_in     (clk_sys_in),
    .host_we_in     (mem_store),
    .host_addr_in   (cursor_q[ADDR_W-1:0]),
    .host_wdata_in  (apb_req_in.pwdata[7:0]),
    .host_rdata_out (mem_rdata),
    .disp_rd_in     (disp_rd_in),
    .disp_addr_in   (disp_addr_in),
    .disp_rdata_out (disp_byte)
  );

  // Fetched byte is valid one cycle after the request
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      disp_byte_valid_q <= 1'b0;
    else
      disp_byte_valid_q <= disp_rd_in;
  end

  // One shifter on the merged stream, so scroll is global to all layers
  pixel_shifter u_pixel_shifter (
    .clk_sys_in       (clk_sys_in),
    .rst_n_in         (rst_n_in),
    .byte_valid_in    (disp_byte_valid_q),
    .byte_in          (disp_byte),
    .shift_in         (scroll_q),
    .pixels_valid_out (disp_valid_out),
    .pixels_out       (disp_pixels_out)
  );

  // Depth decode; the reserved code is flagged and reports zero depth
  assign depth_bpp_out      = (depth_q == `SCD_DEPTH_1BPP) ? 3'd1 :
                              (depth_q == `SCD_DEPTH_2BPP) ? 3'd2 :
                              (depth_q == `SCD_DEPTH_4BPP) ? 3'd4 : 3'd0;
  assign depth_reserved_out = (depth_q == 2'h3);
  assign pixel_scroll_out   = scroll_q;
  assign cursor_out         = cursor_q;

endmodule // scroll_cursor_depth_regs

// ==== scd_regs_chk.sv ====
// Concurrent checks on the ports of the scroll, cursor and depth register bank
`timescale 1ns/1ps
`include "scd_map.svh"
module scd_regs_chk #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic                 clk_sys_in,
  input wire logic                 rst_n_in,
  // APB side
  input wire scd_pkg::apb_req_type apb_req_in,
  input wire logic                 pready_out,
  input wire logic          [31:0] prdata_out,
  input wire logic                 pslverr_out,
  // Display side
  input wire logic                 disp_rd_in,
  input wire logic    [ADDR_W-1:0] disp_addr_in,
  input wire logic                 disp_valid_out,
  input wire logic           [7:0] disp_pixels_out,
  input wire logic           [2:0] pixel_scroll_out,
  input wire logic           [2:0] depth_bpp_out,
  input wire logic                 depth_reserved_out,
  input wire logic          [15:0] cursor_out
);
  localparam logic [11:0] A_SCR = 12'(4 * `SCD_IDX_PIXEL_SCROLL);
  localparam logic [11:0] A_CWL = 12'(4 * `SCD_IDX_CURSOR_WRITE_LOW);
  localparam logic [11:0] A_CWH = 12'(4 * `SCD_IDX_CURSOR_WRITE_HIGH);
  localparam logic [11:0] A_CRL = 12'(4 * `SCD_IDX_CURSOR_READ_LOW);
  localparam logic [11:0] A_DEP = 12'(4 * `SCD_IDX_PIXEL_DEPTH);
  localparam logic [11:0] A_DAT = 12'(4 * `SCD_IDX_PARAM_DATA);
  localparam logic [11:0] A_CMD = 12'(4 * `SCD_IDX_COMMAND);
  // Access phase decode; slices are named so that $past sees plain signals
  wire logic        acc    = apb_req_in.psel & apb_req_in.penable;
  wire logic        wr_acc = acc & apb_req_in.pwrite;
  wire logic [11:0] pa     = apb_req_in.paddr;
  wire logic [7:0]  wd8    = apb_req_in.pwdata[7:0];
  wire logic [2:0]  wd3    = apb_req_in.pwdata[2:0];
  wire logic [1:0]  wd2    = apb_req_in.pwdata[1:0];
  // Shadow of the cursor write bytes; a one-byte load keeps the other last written byte,
  // not the byte of the stepped cursor
  logic [7:0]       lc_q;
  logic [1:0]       np_q;
  logic [7:0]       cwl_q;
  logic [7:0]       cwh_q;
  wire logic        par_wr = wr_acc && pa == A_DAT && lc_q == `SCD_CODE_CURSOR_LOAD;

  // Last command byte, parameter count and cursor write bytes seen on the bus
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lc_q  <= 8'h00;
      np_q  <= 2'h0;
      cwl_q <= 8'h00;
      cwh_q <= 8'h00;
    end
    else
    begin
      if (wr_acc && pa == A_CMD)
        lc_q <= wd8;
      if (wr_acc && pa == A_CMD)
        np_q <= 2'h0;
      else if (acc && pa == A_DAT && np_q != 2'h2)
        np_q <= np_q + 2'h1;
      if ((wr_acc && pa == A_CWL) || (par_wr && np_q == 2'h0))
        cwl_q <= wd8;
      if ((wr_acc && pa == A_CWH) || (par_wr && np_q == 2'h1))
        cwh_q <= wd8;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  reset_values_a: assert property (
    rst_n_in && !$past(rst_n_in) |-> cursor_out == 16'h0000 && pixel_scroll_out == 3'h0
      && depth_bpp_out == 3'h1 && !depth_reserved_out) else $error("bad state after reset");
  scroll_write_a: assert property (
    wr_acc && pa == A_SCR |=> pixel_scroll_out == $past(wd3)) else $error("scroll not loaded");
  depth_write_a: assert property (
    wr_acc && pa == A_DEP |=> depth_bpp_out == ($past(wd2) == 2'h3 ? 3'h0 : 3'h1 << $past(wd2))
      && depth_reserved_out == ($past(wd2) == 2'h3)) else $error("depth decode wrong");
  cursor_low_a: assert property (
    wr_acc && pa == A_CWL |=> cursor_out == {cwh_q, $past(wd8)})
    else $error("cursor low byte wrong");
  cursor_high_a: assert property (
    wr_acc && pa == A_CWH |=> cursor_out == {$past(wd8), cwl_q})
    else $error("cursor high byte wrong");
  cursor_stable_a: assert property (
    !(acc && (pa == A_CWL || pa == A_CWH || pa == A_DAT)) |=> $stable(cursor_out))
    else $error("cursor moved without cause");
  cursor_read_a: assert property (
    acc && !apb_req_in.pwrite && pa == A_CRL |-> prdata_out == {24'h0, cursor_out[7:0]})
    else $error("cursor read low wrong");
  fetch_valid_a: assert property (
    disp_rd_in |-> ##2 disp_valid_out) else $error("fetch output missing");
endmodule // scd_regs_chk

bind scroll_cursor_depth_regs scd_regs_chk #(.ADDR_W(ADDR_W)) chk_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .apb_req_in(apb_req_in),
  .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
  .disp_rd_in(disp_rd_in), .disp_addr_in(disp_addr_in), .disp_valid_out(disp_valid_out),
  .disp_pixels_out(disp_pixels_out), .pixel_scroll_out(pixel_scroll_out),
  .depth_bpp_out(depth_bpp_out), .depth_reserved_out(depth_reserved_out),
  .cursor_out(cursor_out));

// ==== host_apb_model.sv ====
// Host processor model that drives the APB side of the register bank
`timescale 1ns/1ps
module host_apb_model (
  // Clock
  input  wire logic            clk_sys_in,
  // Bus to the bank
  output scd_pkg::apb_req_type apb_req_out,
  input  wire logic            pready_in,
  input  wire logic     [31:0] prdata_in,
  input  wire logic            pslverr_in
);
  // Depth last written directly; scroll must stay zero outside one bit per pixel, here forced only on direct scroll writes
  logic depth_nz = 1'b0;

  initial apb_req_out = '0;

  // Row pitch, char RAM use and layer depths sit outside this bank
  // One transfer, entered just after an edge; an idle cycle follows it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    if (w && a == 12'h080)
      depth_nz = (d[1:0] != 2'h0);
    if (w && a == 12'h06c && depth_nz)
      d = 32'h0;
    apb_req_out.psel    <= 1'b1;
    apb_req_out.penable <= 1'b0;
    apb_req_out.pwrite  <= w;
    apb_req_out.paddr   <= a;
    apb_req_out.pwdata  <= d;
    @(posedge clk_sys_in);
    apb_req_out.penable <= 1'b1;
    do @(posedge clk_sys_in);
    while (pready_in !== 1'b1);
    q = prdata_in;
    err = pslverr_in;
    apb_req_out.psel    <= 1'b0;
    apb_req_out.penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask
endmodule // host_apb_model

// ==== scroll_cursor_depth_regs_tb.sv ====
// Self-checking bench for the scroll, cursor and depth register bank
`timescale 1ns/1ps
`include "scd_map.svh"
module scroll_cursor_depth_regs_tb;
  localparam int          AW    = 8;
  localparam logic [11:0] A_SCR = 12'(4 * `SCD_IDX_PIXEL_SCROLL);
  localparam logic [11:0] A_CWL = 12'(4 * `SCD_IDX_CURSOR_WRITE_LOW);
  localparam logic [11:0] A_CWH = 12'(4 * `SCD_IDX_CURSOR_WRITE_HIGH);
  localparam logic [11:0] A_CRL = 12'(4 * `SCD_IDX_CURSOR_READ_LOW);
  localparam logic [11:0] A_CRH = 12'(4 * `SCD_IDX_CURSOR_READ_HIGH);
  localparam logic [11:0] A_DEP = 12'(4 * `SCD_IDX_PIXEL_DEPTH);
  localparam logic [11:0] A_CMD = 12'(4 * `SCD_IDX_COMMAND);
  localparam logic [11:0] A_DAT = 12'(4 * `SCD_IDX_PARAM_DATA);
  logic                 clk_sys_in, rst_n_in, disp_rd, pready, pslverr, disp_valid;
  logic                 reserved, err;
  logic          [31:0] prdata, v, q;
  logic        [AW-1:0] disp_addr;
  logic           [7:0] disp_pix;
  logic           [7:0] mem_b [3];
  logic           [2:0] pixel_scroll, depth_bpp;
  logic          [15:0] cursor;
  scd_pkg::apb_req_type apb_req;
  int                   error_cnt = 0;
  int                   n_compared = 0;

  host_apb_model hb (.clk_sys_in(clk_sys_in), .apb_req_out(apb_req), .pready_in(pready),
    .prdata_in(prdata), .pslverr_in(pslverr));
  scroll_cursor_depth_regs #(.ADDR_W(AW)) DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .apb_req_in(apb_req), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .disp_rd_in(disp_rd), .disp_addr_in(disp_addr), .disp_valid_out(disp_valid),
    .disp_pixels_out(disp_pix), .pixel_scroll_out(pixel_scroll), .depth_bpp_out(depth_bpp),
    .depth_reserved_out(reserved), .cursor_out(cursor));

  // 10 MHz system clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // Expected bits per pixel for a depth code
  function automatic logic [2:0] bpp(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h1 << c;
  endfunction

  // Expected output byte: previous and current byte shifted left by the scroll
  function automatic logic [7:0] shifted(input logic [7:0] a, input logic [7:0] b,
                                         input logic [2:0] s);
    logic [15:0] t;
    t = {a, b} << s;
    return t[15:8];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    hb.xfer(1'b1, a, d, q, err);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    hb.xfer(1'b0, a, 32'h0, q, err);
    chk(q, exp);
    chk({31'h0, err}, {31'h0, e});
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #(20000 * 100);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h1842));
    rst_n_in = 1'b0;
    disp_rd = 1'b0;
    disp_addr = '0;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rdchk(A_SCR, 32'h0, 1'b0);
    rdchk(A_DEP, 32'h0, 1'b0);
    rdchk(A_CRH, 32'h0, 1'b0);
    rdchk(12'h0fc, 32'h0, 1'b1);
    // Every depth code, directly with random upper bits, then by command
    for (int c = 0; c < 4; c++)
    begin
      v = $urandom();
      v[1:0] = c[1:0];
      wr(A_DEP, v);
      chk(32'(depth_bpp), 32'(bpp(v[1:0])));
      chk(32'(reserved), 32'(v[1:0] == 2'h3));
      rdchk(A_DEP, 32'(v[1:0]), 1'b0);
      wr(A_DEP, 32'h0);
      wr(A_CMD, 32'h60);
      wr(A_DAT, v);
      chk(32'(depth_bpp), 32'(bpp(v[1:0])));
    end
    wr(A_DEP, 32'h0);
    // Direct cursor load; write-only and read-only places are refused quietly
    v = $urandom();
    wr(A_CWL, v);
    wr(A_CWH, v >> 8);
    chk({16'h0, cursor}, {16'h0, v[15:0]});
    rdchk(A_CRL, {24'h0, v[7:0]}, 1'b0);
    rdchk(A_CWL, 32'h0, 1'b0);
    wr(A_CRL, 32'hff);
    chk({16'h0, cursor}, {16'h0, v[15:0]});
    wr(A_CMD, 32'h47);
    rdchk(A_DAT, {24'h0, v[7:0]}, 1'b0);
    rdchk(A_DAT, {24'h0, v[15:8]}, 1'b0);
    // Load near the top so that stores wrap the cursor
    wr(A_CMD, 32'h46);
    wr(A_DAT, 32'hfe);
    wr(A_DAT, 32'hff);
    chk({16'h0, cursor}, 32'hfffe);
    wr(A_CMD, 32'h42);
    for (int k = 0; k < 3; k++)
    begin
      mem_b[k] = 8'($urandom());
      wr(A_DAT, {24'h0, mem_b[k]});
    end
    chk({16'h0, cursor}, 32'h0001);
    wr(A_CMD, 32'h46);
    wr(A_DAT, 32'hfe);
    wr(A_DAT, 32'hff);
    wr(A_CMD, 32'h43);
    rdchk(A_DAT, {24'h0, mem_b[0]}, 1'b0);
    rdchk(A_DAT, {24'h0, mem_b[1]}, 1'b0);
    wr(A_CMD, 32'h43);
    rdchk(A_DAT, {24'h0, mem_b[2]}, 1'b0);
    // Scroll by command leaves the cursor where it was
    v = $urandom();
    wr(A_CMD, 32'h5a);
    wr(A_DAT, v);
    chk(32'(pixel_scroll), 32'(v[2:0]));
    chk({16'h0, cursor}, 32'h0001);
    // A lone low byte reuses the last written high byte, not the stepped one
    wr(A_CWL, 32'h34);
    chk({16'h0, cursor}, 32'hff34);
    // Every scroll count on a fetched pair of bytes
    for (int s = 0; s < 8; s++)
    begin
      wr(A_SCR, 32'(s) | 32'hf8);
      rdchk(A_SCR, 32'(s), 1'b0);
      disp_rd <= 1'b1;
      disp_addr <= 8'hfe;
      @(posedge clk_sys_in);
      disp_addr <= 8'hff;
      @(posedge clk_sys_in);
      disp_rd <= 1'b0;
      @(posedge clk_sys_in);
      // Look mid-cycle, where the second shifted byte is settled
      @(negedge clk_sys_in);
      chk({31'h0, disp_valid}, 32'h1);
      chk({24'h0, disp_pix}, {24'h0, shifted(mem_b[0], mem_b[1], 3'(s))});
      @(posedge clk_sys_in);
    end
    // Second reset in mid-run
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk({13'h0, pixel_scroll, cursor}, 32'h0);
    chk(32'(depth_bpp), 32'h1);
    chk({31'h0, disp_valid}, 32'h0);
    rdchk(A_CRL, 32'h0, 1'b0);
    complete_run();
  end
endmodule // scroll_cursor_depth_regs_tb
